/* bench/rate_sensor_user_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rate_sensor_user_register_bank_tb
    import rsu_pkg::*;
;
    localparam int BACKUP_T = 20;
    localparam logic [15:0] PART_CODE = 16'hC3C3; // arbitrary value
    logic clock, reset_n, powerOnReset_n, clockEnable;
    logic spiClock, spiSelect_n, spiDataIn, spiDataOut, spiDataOutEn, backupBusy;
    logic [15:0] temperatureIn;
    logic [31:0] rateIn;
    logic prevRead;
    int mismatches, num_checks, cycles, busyCycles;

    rsu_reg_bank #(
        .BackupCycles(BACKUP_T),
        .PartId(PART_CODE),
        .LotOne(16'h1111),
        .LotTwo(16'h2222),
        .LotThree(16'h3333),
        .SerialNo(16'h4444)
    ) u_rsu_reg_bank (
        .clock(clock),
        .reset_n(reset_n),
        .powerOnReset_n(powerOnReset_n),
        .clockEnable(clockEnable),
        .spiClock(spiClock),
        .spiSelect_n(spiSelect_n),
        .spiDataIn(spiDataIn),
        .spiDataOut(spiDataOut),
        .spiDataOutEn(spiDataOutEn),
        .temperatureIn(temperatureIn),
        .rateIn(rateIn),
        .backupBusy(backupBusy)
    );

    rsu_host_model u_rsu_host_model (
        .spiClock(spiClock),
        .spiSelect_n(spiSelect_n),
        .spiDataIn(spiDataIn),
        .spiDataOut(spiDataOut),
        .spiDataOutEn(spiDataOutEn)
    );

    always #20 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (backupBusy === 1'b1)
            busyCycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic writeByte(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] rx;
        logic [1:0] oe;
        u_rsu_host_model.xfer({1'b1, a, d}, rx, oe);
        check({14'h0000, oe}, {14'h0000, prevRead, 1'b0});
        prevRead = 1'b0;
    endtask

    // pipelined reads: each frame carries the next request
    task automatic readList(input logic [6:0] a[$], input logic [15:0] e[$]);
        logic [15:0] rx;
        logic [1:0] oe;
        int i;
        for (i = 0; i <= a.size(); i++)
        begin
            u_rsu_host_model.xfer({1'b0, (i < a.size()) ? a[i] : 7'h00, 8'h00}, rx, oe);
            check({14'h0000, oe}, {14'h0000, prevRead, 1'b0});
            prevRead = 1'b1;
            if (i > 0)
                check(rx, e[i-1]);
        end
    endtask

    task automatic resetPulse();
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        prevRead = 1'b0;
    endtask

    task automatic t_defaults();
        readList('{OFS_BIAS_LO, OFS_BIAS_HI, OFS_ALM1_LEVEL, OFS_ALM2_LEVEL, OFS_ALM1_PERIOD, OFS_ALM2_PERIOD,
            OFS_ALM_CONFIG, OFS_AUX_PIN, OFS_MISC, OFS_SAMPLE, OFS_FILTER, OFS_DEC},
            '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h0006, 16'h001F, 16'h0000, 16'h0000});
    endtask

    task automatic t_bytes();
        writeByte(OFS_BIAS_LO, 8'h34);
        writeByte(7'h09, 8'h12);
        writeByte(7'h1D, 8'hAB);
        readList('{OFS_BIAS_LO, OFS_MISC}, '{16'h1234, 16'hAB06});
    endtask

    task automatic t_readonly();
        writeByte(OFS_WRITE_COUNT, 8'h55);
        writeByte(OFS_TEMP, 8'h11);
        writeByte(OFS_PART_ID, 8'h66);
        writeByte(7'h0C, 8'h77);
        writeByte(7'h2A, 8'h88);
        writeByte(OFS_SLEEP, 8'h01);
        readList('{OFS_WRITE_COUNT, OFS_PART_ID, OFS_LOT1, OFS_LOT2, OFS_LOT3, OFS_SERIAL, 7'h0C, 7'h2A,
            OFS_SLEEP, OFS_CMD, OFS_STATUS, 7'h7E},
            '{16'h0000, PART_CODE, 16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h0000, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h0000});
    endtask

    task automatic t_outputs();
        logic [4:0] dec[3] = '{5'h00, 5'h03, 5'h10};
        logic [15:0] mask;
        int k;
        @(posedge clock);
        temperatureIn <= 16'hFFFE;
        rateIn <= 32'h9FD1B6D5;
        for (k = 0; k < 3; k++)
        begin
            writeByte(OFS_DEC, {3'b000, dec[k]});
            mask = (dec[k] >= 5'h10) ? 16'hFFFF : ~(16'hFFFF >> dec[k]);
            readList('{OFS_RATE_LO, OFS_RATE_HI, OFS_TEMP}, '{16'hB6D5 & mask, 16'h9FD1, 16'hFFFE});
        end
        @(posedge clock);
        temperatureIn <= 16'h0000;
        rateIn <= 32'h0000FFFF;
        readList('{OFS_RATE_HI, OFS_TEMP}, '{16'h0000, 16'h0000});
    endtask

    task automatic t_backup();
        int n;
        resetPulse();
        readList('{OFS_BIAS_LO, OFS_MISC}, '{16'h0000, MISC_DEFAULT});
        writeByte(OFS_BIAS_HI, 8'h5A);
        writeByte(7'h0B, 8'hC3);
        busyCycles = 0;
        writeByte(OFS_CMD, 8'h08);
        // supply held and bus quiet until the store finishes
        for (n = 0; n < 300 && !(busyCycles > 0 && backupBusy === 1'b0); n++)
            @(posedge clock);
        check(16'(busyCycles), 16'(BACKUP_T));
        readList('{OFS_WRITE_COUNT, OFS_BIAS_HI}, '{16'h0001, 16'hC35A});
        resetPulse();
        readList('{OFS_BIAS_HI, OFS_WRITE_COUNT, OFS_CMD, OFS_BIAS_LO},
            '{16'hC35A, 16'h0001, 16'h0000, 16'h0000});
    endtask

    initial
    begin
        clock = 1'b0;
        reset_n = 1'b0;
        powerOnReset_n = 1'b0;
        clockEnable = 1'b1;
        temperatureIn = 16'h0000;
        rateIn = 32'h00000000;
        prevRead = 1'b0;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        busyCycles = 0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        powerOnReset_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_defaults();
        t_bytes();
        t_readonly();
        t_outputs();
        t_backup();
        final_report();
    end
endmodule // rate_sensor_user_register_bank_tb
`default_nettype wire

/* bench/rsu_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsu_host_model
(
    output logic spiClock,
    output logic spiSelect_n,
    output logic spiDataIn,
    input wire logic spiDataOut,
    input wire logic spiDataOutEn
);
    logic linkClock;
    logic lastMiso;

    initial
    begin
        spiClock = 1'b1;
        spiSelect_n = 1'b1;
        spiDataIn = 1'b0;
        lastMiso = 1'b0;
        linkClock = 1'b0;
        #5;
        forever #16 linkClock = ~linkClock;
    end

    // one frame; oe = {driven during frame, driven after deselect}
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic [1:0] oe);
        int i;
        oe = 2'b00;
        rx = 16'h0000;
        @(posedge linkClock);
        spiSelect_n <= 1'b0;
        for (i = 15; i >= 0; i--)
        begin
            @(negedge linkClock);
            spiClock <= 1'b0;
            spiDataIn <= tx[i];
            @(posedge linkClock);
            spiClock <= 1'b1;
            // undriven line shows the inverse of its last level
            lastMiso = (spiDataOutEn === 1'b1) ? spiDataOut : ~lastMiso;
            rx[i] = lastMiso;
            oe[1] = oe[1] | (spiDataOutEn === 1'b1);
        end
        @(posedge linkClock);
        spiSelect_n <= 1'b1;
        spiDataIn <= ~spiDataIn;
        @(posedge linkClock);
        oe[0] = (spiDataOutEn !== 1'b0);
        // clock stands still; gap lets the answer word load
        repeat (10) @(posedge linkClock);
    endtask
endmodule // rsu_host_model
`default_nettype wire

/* src/rsu_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rsu_link_if;
    logic [15:0] rxWord;
    logic rxToggle;
    logic [15:0] txWord;
    logic txEnable;
    modport link (output rxWord, output rxToggle, input txWord, input txEnable);
    modport core (input rxWord, input rxToggle, output txWord, output txEnable);
endinterface
`default_nettype wire

/* src/rsu_pkg.sv */
`default_nettype none
package rsu_pkg;
    localparam int RSU_WORDS = 32;
    localparam int WORD_W = 16;
    localparam int LANE_W = 8;
    localparam int ADDR_W = 7;
    localparam int IDX_W = 5;
    localparam int FRAME_CNT_W = 4;
    localparam logic [FRAME_CNT_W-1:0] FRAME_FIRST = 4'h0;
    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = 4'hF;
    localparam int FRM_WRITE_BIT = 15;
    localparam int FRM_ADDR_LO = 8;
    localparam int DEC_FIELD_W = 5;
    localparam int CMD_BACKUP_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam logic [WORD_W-1:0] ALL_ONES = 16'hFFFF;
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [WORD_W-1:0] MISC_DEFAULT = 16'h0006;
    localparam logic [WORD_W-1:0] SAMPLE_DEFAULT = 16'h001F;
    localparam logic [ADDR_W-1:0] OFS_WRITE_COUNT = 7'h00;
    localparam logic [ADDR_W-1:0] OFS_TEMP = 7'h02;
    localparam logic [ADDR_W-1:0] OFS_RATE_LO = 7'h04;
    localparam logic [ADDR_W-1:0] OFS_RATE_HI = 7'h06;
    localparam logic [ADDR_W-1:0] OFS_BIAS_LO = 7'h08;
    localparam logic [ADDR_W-1:0] OFS_BIAS_HI = 7'h0A;
    localparam logic [ADDR_W-1:0] OFS_ALM1_LEVEL = 7'h10;
    localparam logic [ADDR_W-1:0] OFS_ALM2_LEVEL = 7'h12;
    localparam logic [ADDR_W-1:0] OFS_ALM1_PERIOD = 7'h14;
    localparam logic [ADDR_W-1:0] OFS_ALM2_PERIOD = 7'h16;
    localparam logic [ADDR_W-1:0] OFS_ALM_CONFIG = 7'h18;
    localparam logic [ADDR_W-1:0] OFS_AUX_PIN = 7'h1A;
    localparam logic [ADDR_W-1:0] OFS_MISC = 7'h1C;
    localparam logic [ADDR_W-1:0] OFS_SAMPLE = 7'h1E;
    localparam logic [ADDR_W-1:0] OFS_FILTER = 7'h20;
    localparam logic [ADDR_W-1:0] OFS_DEC = 7'h22;
    localparam logic [ADDR_W-1:0] OFS_SLEEP = 7'h24;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 7'h26;
    localparam logic [ADDR_W-1:0] OFS_CMD = 7'h28;
    localparam logic [ADDR_W-1:0] OFS_LOT1 = 7'h32;
    localparam logic [ADDR_W-1:0] OFS_LOT2 = 7'h34;
    localparam logic [ADDR_W-1:0] OFS_LOT3 = 7'h36;
    localparam logic [ADDR_W-1:0] OFS_PART_ID = 7'h38;
    localparam logic [ADDR_W-1:0] OFS_SERIAL = 7'h3A;
    localparam longint CLOCK_HZ = 25000000;
    localparam longint BACKUP_TIME_MS = 72;
    localparam int BACKUP_CYCLES = int'((BACKUP_TIME_MS * CLOCK_HZ) / 1000);

    typedef logic [RSU_WORDS-1:0][WORD_W-1:0] rsu_mem_t;
    typedef enum logic [1:0] {ST_RESTORE, ST_IDLE, ST_BACKUP} rsu_state_t;
    typedef struct packed {
        logic [FRAME_CNT_W-1:0] bitCount;
        logic [WORD_W-2:0] shift;
    } rsu_rx_t;
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic toggle;
    } rsu_hand_t;
    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic drive;
    } rsu_tx_t;
endpackage
`default_nettype wire

/* src/rsu_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module rsu_reg_bank
    import rsu_pkg::*;
#(
    parameter int BackupCycles = BACKUP_CYCLES,
    parameter logic [WORD_W-1:0] PartId = 16'h5A5A, // arbitrary value
    parameter logic [WORD_W-1:0] LotOne = 16'h0000,
    parameter logic [WORD_W-1:0] LotTwo = 16'h0000,
    parameter logic [WORD_W-1:0] LotThree = 16'h0000,
    parameter logic [WORD_W-1:0] SerialNo = 16'h0000
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic powerOnReset_n,
    input wire logic clockEnable,
    input wire logic spiClock,
    input wire logic spiSelect_n,
    input wire logic spiDataIn,
    output logic spiDataOut,
    output logic spiDataOutEn,
    input wire logic [WORD_W-1:0] temperatureIn,
    input wire logic [2*WORD_W-1:0] rateIn,
    output logic backupBusy
);
    localparam int CNT_W = $clog2(BackupCycles + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(BackupCycles);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef struct packed {
        rsu_state_t state;
        rsu_mem_t sram;
        logic tglSeen;
        logic [WORD_W-1:0] txWord;
        logic txEnable;
        logic [CNT_W-1:0] busyCount;
        logic [WORD_W-1:0] tempR;
        logic [2*WORD_W-1:0] rateR;
    } rsu_core_t;

    typedef struct packed {
        rsu_mem_t mem;
    } rsu_nv_t;

    function automatic logic [IDX_W-1:0] wordIdx(input logic [ADDR_W-1:0] a);
        return a[IDX_W:1];
    endfunction

    function automatic logic [ADDR_W-1:0] evenAddr(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:1], 1'b0};
    endfunction

    function automatic logic isWritable(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] e;
        e = evenAddr(a);
        return (e == OFS_BIAS_LO) || (e == OFS_BIAS_HI)
            || ((e >= OFS_ALM1_LEVEL) && (e <= OFS_SLEEP));
    endfunction

    function automatic logic isBacked(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] e;
        e = evenAddr(a);
        return (e == OFS_WRITE_COUNT) || isWritable(a)
            || ((e >= OFS_LOT1) && (e <= OFS_SERIAL));
    endfunction

    function automatic logic [WORD_W-1:0] extMask(input logic [DEC_FIELD_W-1:0] d);
        return ~(ALL_ONES >> d);
    endfunction

    function automatic logic [WORD_W-1:0] readMap(input logic [ADDR_W-1:0] a, input rsu_mem_t m,
        input logic [WORD_W-1:0] t, input logic [2*WORD_W-1:0] r, input logic busy);
        logic [WORD_W-1:0] v;
        v = ZERO_WORD;
        case (evenAddr(a))
            OFS_TEMP: v = t;
            OFS_RATE_LO: v = r[WORD_W-1:0] & extMask(m[wordIdx(OFS_DEC)][DEC_FIELD_W-1:0]);
            OFS_RATE_HI: v = r[2*WORD_W-1:WORD_W];
            OFS_STATUS: v[STAT_BUSY_BIT] = busy;
            OFS_SLEEP, OFS_CMD: v = ZERO_WORD;
            default:
            begin
                if (isBacked(a))
                    v = m[wordIdx(a)];
                else
                    v = ZERO_WORD;
            end
        endcase
        return v;
    endfunction

    function automatic rsu_mem_t nvInit();
        rsu_mem_t m;
        m = '0;
        m[wordIdx(OFS_MISC)] = MISC_DEFAULT;
        m[wordIdx(OFS_SAMPLE)] = SAMPLE_DEFAULT;
        m[wordIdx(OFS_LOT1)] = LotOne;
        m[wordIdx(OFS_LOT2)] = LotTwo;
        m[wordIdx(OFS_LOT3)] = LotThree;
        m[wordIdx(OFS_SERIAL)] = SerialNo;
        m[wordIdx(OFS_PART_ID)] = PartId;
        return m;
    endfunction

    localparam rsu_mem_t NV_INIT = nvInit();

    rsu_core_t s_r;
    rsu_core_t s_nxt;
    rsu_nv_t nv_r;
    rsu_nv_t nv_nxt;
    logic syncTgl;
    logic frameEvt;
    logic frmWrite;
    logic [ADDR_W-1:0] frmAddr;
    logic [LANE_W-1:0] frmData;
    logic wrOk;
    logic backupStart;
    logic backupDone;

    rsu_link_if lnk();

    rsu_spi_link u_link (
        .spiClock(spiClock),
        .reset_n(reset_n),
        .spiSelect_n(spiSelect_n),
        .spiDataIn(spiDataIn),
        .spiDataOut(spiDataOut),
        .spiDataOutEn(spiDataOutEn),
        .lnk(lnk.link)
    );

    rsu_sync #(.W(1)) u_tgl_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clockEnable(clockEnable),
        .din(lnk.rxToggle),
        .dout(syncTgl)
    );

    // frame word is held stable for a whole frame after its toggle
    assign frmWrite = lnk.rxWord[FRM_WRITE_BIT];
    assign frmAddr = lnk.rxWord[FRM_WRITE_BIT-1:FRM_ADDR_LO];
    assign frmData = lnk.rxWord[LANE_W-1:0];
    assign wrOk = isWritable(frmAddr);
    assign frameEvt = clockEnable && (syncTgl != s_r.tglSeen) && (s_r.state != ST_RESTORE);
    assign backupStart = frameEvt && frmWrite && (evenAddr(frmAddr) == OFS_CMD) && !frmAddr[0]
        && frmData[CMD_BACKUP_BIT] && (s_r.state == ST_IDLE);
    assign backupDone = clockEnable && (s_r.state == ST_BACKUP) && (s_r.busyCount == CNT_ONE);

    always_comb
    begin
        s_nxt = s_r;
        if (clockEnable)
        begin
            s_nxt.tempR = temperatureIn;
            s_nxt.rateR = rateIn;
            case (s_r.state)
                ST_RESTORE:
                begin
                    for (int i = 0; i < RSU_WORDS; i++)
                    begin
                        if (isBacked(ADDR_W'(2 * i)))
                            s_nxt.sram[i] = nv_r.mem[i];
                    end
                    s_nxt.state = ST_IDLE;
                end
                ST_BACKUP:
                begin
                    s_nxt.busyCount = s_r.busyCount - CNT_ONE;
                    if (s_r.busyCount == CNT_ONE)
                    begin
                        s_nxt.state = ST_IDLE;
                        s_nxt.sram[wordIdx(OFS_WRITE_COUNT)] = nv_r.mem[wordIdx(OFS_WRITE_COUNT)] + 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
            if (frameEvt)
            begin
                s_nxt.tglSeen = syncTgl;
                s_nxt.txEnable = !frmWrite;
                if (!frmWrite)
                    s_nxt.txWord = readMap(frmAddr, s_r.sram, s_r.tempR, s_r.rateR,
                        s_r.state == ST_BACKUP);
                else if (wrOk)
                begin
                    if (frmAddr[0])
                        s_nxt.sram[wordIdx(frmAddr)][LANE_W +: LANE_W] = frmData;
                    else
                        s_nxt.sram[wordIdx(frmAddr)][0 +: LANE_W] = frmData;
                end
                if (backupStart)
                begin
                    s_nxt.state = ST_BACKUP;
                    s_nxt.busyCount = CNT_LOAD;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // nonvolatile copy survives reset_n; only power-on reloads it with NV_INIT
    always_comb
    begin
        nv_nxt = nv_r;
        if (backupDone)
        begin
            for (int i = 0; i < RSU_WORDS; i++)
            begin
                if (isWritable(ADDR_W'(2 * i)))
                    nv_nxt.mem[i] = s_r.sram[i];
            end
            nv_nxt.mem[wordIdx(OFS_WRITE_COUNT)] = nv_r.mem[wordIdx(OFS_WRITE_COUNT)] + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge powerOnReset_n)
    begin
        if (!powerOnReset_n)
            nv_r <= '{mem: NV_INIT};
        else
            nv_r <= nv_nxt;
    end

    assign lnk.txWord = s_r.txWord;
    assign lnk.txEnable = s_r.txEnable;
    assign backupBusy = (s_r.state == ST_BACKUP);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    logic [WORD_W-1:0] rateLowView;
    assign rateLowView = readMap(OFS_RATE_LO, s_r.sram, s_r.tempR, s_r.rateR, 1'b0);

    sequence seqWriteFrame;
        frameEvt && frmWrite && wrOk;
    endsequence

    sequence seqRestoreStep;
        // sampled reset_n keeps the release edge itself out
        (s_r.state == ST_RESTORE) && clockEnable && reset_n;
    endsequence

    a_write_byte_store: assert property (seqWriteFrame |=>
        (($past(frmAddr[0]) ? s_r.sram[$past(wordIdx(frmAddr))][LANE_W +: LANE_W]
            : s_r.sram[$past(wordIdx(frmAddr))][0 +: LANE_W]) == $past(frmData)))
        else $error("written byte not stored in its lane");

    a_ro_write_ignored: assert property (frameEvt && frmWrite && !wrOk && (s_r.state == ST_IDLE)
        |=> (s_r.sram == $past(s_r.sram)))
        else $error("write to read-only or reserved changed a register");

    a_read_enable: assert property (frameEvt |=> (s_r.txEnable == !$past(frmWrite)))
        else $error("output enable does not follow request type");

    a_zero_reads: assert property (frameEvt && !frmWrite
        && ((evenAddr(frmAddr) == OFS_CMD) || (evenAddr(frmAddr) == OFS_SLEEP) || frmAddr[ADDR_W-1])
        |=> (s_r.txWord == ZERO_WORD))
        else $error("command, sleep or reserved read not zero");

    a_backup_start: assert property (backupStart |=> (s_r.state == ST_BACKUP) && (s_r.busyCount == CNT_LOAD))
        else $error("backup did not start with full count");

    a_nv_only_backup: assert property (!backupDone |=> (nv_r == $past(nv_r)))
        else $error("nonvolatile copy changed without backup");

    a_restore_loads: assert property (seqRestoreStep |=> (s_r.state == ST_IDLE)
        && (s_r.sram[wordIdx(OFS_MISC)] == $past(nv_r.mem[wordIdx(OFS_MISC)]))
        && (s_r.sram[wordIdx(OFS_PART_ID)] == $past(nv_r.mem[wordIdx(OFS_PART_ID)])))
        else $error("restore did not load saved settings");

    a_flash_count: assert property (backupDone |=>
        (nv_r.mem[wordIdx(OFS_WRITE_COUNT)] == $past(nv_r.mem[wordIdx(OFS_WRITE_COUNT)]) + 1'b1)
        && (s_r.state == ST_IDLE))
        else $error("backup did not advance write count");

    a_ext_mask: assert property ((s_r.sram[wordIdx(OFS_DEC)][DEC_FIELD_W-1:0] == '0)
        |-> (rateLowView == ZERO_WORD))
        else $error("extension bits valid with zero decimation");

    sequence seqBackupStep;
        (s_r.state == ST_BACKUP) && clockEnable && (s_r.busyCount != CNT_ONE);
    endsequence

    a_backup_countdown: assert property (seqBackupStep |=> (s_r.state == ST_BACKUP)
        && (s_r.busyCount == ($past(s_r.busyCount) - CNT_ONE)))
        else $error("backup countdown did not advance");

    a_count_mirror: assert property (backupDone |=>
        (s_r.sram[wordIdx(OFS_WRITE_COUNT)] == nv_r.mem[wordIdx(OFS_WRITE_COUNT)]))
        else $error("working write count differs from saved count");

    a_answer_hold: assert property (!frameEvt |=> $stable(s_r.txWord) && $stable(s_r.txEnable))
        else $error("answer word changed between requests");

    a_cmd_no_store: assert property (frameEvt && frmWrite && (evenAddr(frmAddr) == OFS_CMD)
        |=> (s_r.sram[wordIdx(OFS_CMD)] == ZERO_WORD))
        else $error("command bits stored instead of self-clearing");

    a_rate_answer: assert property (frameEvt && !frmWrite && (evenAddr(frmAddr) == OFS_RATE_HI)
        |=> (s_r.txWord == $past(s_r.rateR[2*WORD_W-1:WORD_W])))
        else $error("rate request not answered with the high rate word");

    a_temp_answer: assert property (frameEvt && !frmWrite && (evenAddr(frmAddr) == OFS_TEMP)
        |=> (s_r.txWord == $past(s_r.tempR)))
        else $error("temperature request not answered with the temperature word");
endmodule // rsu_reg_bank
`default_nettype wire

/* src/rsu_spi_link.sv */
`timescale 1ns/1ps
`default_nettype none
module rsu_spi_link
    import rsu_pkg::*;
(
    input wire logic spiClock,
    input wire logic reset_n,
    input wire logic spiSelect_n,
    input wire logic spiDataIn,
    output logic spiDataOut,
    output logic spiDataOutEn,
    rsu_link_if.link lnk
);
    rsu_rx_t rx_r;
    rsu_rx_t rx_nxt;
    rsu_hand_t hand_r;
    rsu_hand_t hand_nxt;
    rsu_tx_t tx_r;
    rsu_tx_t tx_nxt;
    logic frameRst_n;

    // select high ends the frame and clears the bit position
    assign frameRst_n = reset_n & ~spiSelect_n;

    always_comb
    begin
        rx_nxt = rx_r;
        hand_nxt = hand_r;
        rx_nxt.shift = {rx_r.shift[WORD_W-3:0], spiDataIn};
        rx_nxt.bitCount = rx_r.bitCount + 1'b1;
        if (rx_r.bitCount == FRAME_LAST)
        begin
            hand_nxt.word = {rx_r.shift, spiDataIn};
            hand_nxt.toggle = ~hand_r.toggle;
        end
    end

    always_ff @(posedge spiClock or negedge frameRst_n)
    begin
        if (!frameRst_n)
            rx_r <= '0;
        else
            rx_r <= rx_nxt;
    end

    always_ff @(posedge spiClock or negedge reset_n)
    begin
        if (!reset_n)
            hand_r <= '0;
        else
            hand_r <= hand_nxt;
    end

    // answer word is loaded at the first falling edge, then shifted msb first
    always_comb
    begin
        tx_nxt = tx_r;
        if (rx_r.bitCount == FRAME_FIRST)
        begin
            tx_nxt.shift = lnk.txWord;
            tx_nxt.drive = lnk.txEnable;
        end
        else
            tx_nxt.shift = {tx_r.shift[WORD_W-2:0], 1'b0};
    end

    always_ff @(negedge spiClock or negedge frameRst_n)
    begin
        if (!frameRst_n)
            tx_r <= '0;
        else
            tx_r <= tx_nxt;
    end

    assign lnk.rxWord = hand_r.word;
    assign lnk.rxToggle = hand_r.toggle;
    assign spiDataOut = tx_r.shift[WORD_W-1];
    assign spiDataOutEn = tx_r.drive & ~spiSelect_n;
endmodule // rsu_spi_link
`default_nettype wire

/* src/rsu_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rsu_sync
    import rsu_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clockEnable,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } rsu_sync_t;

    rsu_sync_t s_r;
    rsu_sync_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (clockEnable)
        begin
            s_nxt.stage1 = din;
            s_nxt.stage2 = s_r.stage1;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign dout = s_r.stage2;
endmodule // rsu_sync
`default_nettype wire
